// File: hw/aesd_top.sv
// Encoder counters, deviation stop, step/direction mode and event sources of one axis
// Summary of operation
// [RULE1] Built-in encoder counts 1024 steps per shaft rotation
// [RULE2] Built-in encoder position readable and writable as signed 32 bits, parameter 209
// [RULE3] Built-in encoder scale follows microstep setting automatically
// [RULE4] Writing 1 to 210 arms clear-on-null; it drops back to 0 once done
// [RULE5] Motor stops when built-in deviation exceeds parameter 212; zero disables
// [RULE6] Parameter 215 reads absolute single-turn angle 0 to 1023
// [RULE7] External encoder position readable and writable as signed 32 bits, parameter 216
// [RULE8] External scale derives from counts per revolution in 217
// [RULE9] Motor stops when external deviation exceeds parameter 218; zero disables
// [RULE10] External counts track microstep counter one to one when configured right
// [RULE11] Host multiplies encoder lines by four to give counts per rotation
// [RULE12] Parameter 254 = 1 selects step/direction; motion commands then ignored
// [RULE13] Currents, microsteps and standby switching still act in step/direction mode
// [RULE14] General input two stays unconnected in step/direction mode; the code still raises its input 2 event in that mode
// [RULE15] Lowest pending event number is served first
// [RULE16] Three millisecond timers with 32-bit periods raise events
// [RULE17] Stop switches and inputs 0..2 raise events on selected edges
// [RULE18] Microstep setting defaults to 256 per full step
// [RULE19] Deviation checks run continuously and set a sticky error flag
`timescale 1ns/100ps
`include "aesd_consts.svh"
module aesd_top import aesd_pkg::*; #(
  parameter int FULL_STEPS = 200,
  parameter int MS_CYCLES  = `AESD_MS_NS / `AESD_CLK_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Parameter commands
  input  wire logic        cmd_valid,
  input  wire logic        cmd_set,
  input  wire logic        cmd_bank3,
  input  wire logic [7:0]  cmd_num,
  input  wire logic [31:0] cmd_wdata,
  output logic             rsp_valid_q,
  output logic             rsp_err_q,
  output logic [31:0]      rsp_data_q,
  // Motion commands
  input  wire logic        mcmd_valid,
  input  aesd_mcmd_e       mcmd_code,
  input  wire logic [31:0] mcmd_value,
  output logic             mot_valid_q,
  output aesd_mcmd_e       mot_code_q,
  output logic [31:0]      mot_value_q,
  // Motor side
  input  wire logic [31:0] motor_pos,
  input  wire logic        motion_active,
  input  wire logic [9:0]  enc_angle,
  output logic             stop_req_q,
  output logic             step_out_q,
  output logic             dir_out_q,
  output logic             stepdir_mode_q,
  output logic [3:0]       ustep_code_q,
  output logic [7:0]       coil_current_q,
  // Pins
  input  wire logic        quad_a,
  input  wire logic        quad_b,
  input  wire logic        step_in,
  input  wire logic        dir_in,
  input  wire logic        stop_left,
  input  wire logic        stop_right,
  input  wire logic [2:0]  general_in,
  // Events
  input  wire logic        evt_ack,
  output logic             evt_valid_q,
  output logic [7:0]       evt_num_q
);
  localparam int F = `AESD_ENC_FRAC;
  localparam logic [7:0] EVNUM [8] = '{`AESD_EV_TMR0, `AESD_EV_TMR1, `AESD_EV_TMR2,
    `AESD_EV_STOP_L, `AESD_EV_STOP_R, `AESD_EV_IN0, `AESD_EV_IN1, `AESD_EV_IN2};

  // ==========================================
  // Pin synchronisers
  logic [8:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge clk) begin
    sync1_q <= {general_in, stop_right, stop_left, dir_in, step_in, quad_b, quad_a};
    sync2_q <= sync1_q;
    prev_q  <= sync2_q;
  end

  // ==========================================
  // Parameter registers
  logic [31:0]        tmr_per_q [3], tmr_per_d [3];
  logic [1:0]         edge_sel_q [5], edge_sel_d [5];
  logic [3:0]         ustep_d;
  logic [7:0]         run_cur_q, run_cur_d, stby_cur_q, stby_cur_d;
  logic signed [41:0] enc_acc_q, enc_acc_d;
  logic [9:0]         ang_prev_q;
  logic               clr_arm_q, clr_arm_d, stepdir_d;
  logic [31:0]        dev_max_q, dev_max_d, xdev_max_q, xdev_max_d, xcpr_q, xcpr_d;
  logic [31:0]        xpos_q, xpos_d;
  logic signed [33:0] xrem_q, xrem_d;
  logic [1:0]         dev_err_q, dev_err_d, dev_hit;
  logic               rsp_valid_d, rsp_err_d;
  logic [31:0]        rsp_data_d;
  logic [25:0]        m_step;
  logic [9:0]         ang_dlt;
  logic               q_chg, q_up, wr, rd;
  logic [32:0]        diff0, diff1;

  // Microsteps per rotation; the encoder steps below are weighted by this
  assign m_step = 26'(FULL_STEPS) << ustep_code_q; // [RULE3]
  assign ang_dlt = enc_angle - ang_prev_q; // [RULE1]
  assign q_chg = (sync2_q[0] ^ prev_q[0]) ^ (sync2_q[1] ^ prev_q[1]);
  assign q_up  = prev_q[0] ~^ sync2_q[1];
  assign wr = cmd_valid & cmd_set;
  assign rd = cmd_valid & ~cmd_set;
  assign diff0 = {motor_pos[31], motor_pos} - {enc_acc_q[41], enc_acc_q[41:F]};
  assign diff1 = {motor_pos[31], motor_pos} - {xpos_q[31], xpos_q};
  // Deviation checks run every cycle while enabled
  assign dev_hit[0] = (dev_max_q != 32'h0) && // [RULE5] [RULE19]
    ((diff0[32] ? 33'(-diff0) : diff0) > {1'b0, dev_max_q});
  assign dev_hit[1] = (xdev_max_q != 32'h0) && // [RULE9] [RULE19]
    ((diff1[32] ? 33'(-diff1) : diff1) > {1'b0, xdev_max_q});

  always_comb begin
    tmr_per_d = tmr_per_q;
    edge_sel_d = edge_sel_q;
    ustep_d = ustep_code_q;
    run_cur_d = run_cur_q;
    stby_cur_d = stby_cur_q;
    dev_max_d = dev_max_q;
    xdev_max_d = xdev_max_q;
    xcpr_d = xcpr_q;
    stepdir_d = stepdir_mode_q;
    rsp_valid_d = cmd_valid;
    rsp_err_d = 1'b0;
    rsp_data_d = 32'h0;
    // Built-in counter, Q10 fixed point so fine microstep settings keep no drift
    enc_acc_d = enc_acc_q + 42'($signed(ang_dlt) * $signed({1'b0, m_step})); // [RULE1] [RULE3]
    clr_arm_d = clr_arm_q;
    if (clr_arm_q && enc_angle == 10'h0 && ang_prev_q != 10'h0) begin
      enc_acc_d = 42'h0; // [RULE4]
      clr_arm_d = 1'b0; // [RULE4]
    end
    // External counter: remainder carries fractions, drains one count per cycle
    xpos_d = xpos_q;
    xrem_d = xrem_q;
    if (xcpr_q == 32'h0) begin
      if (q_chg) xpos_d = q_up ? xpos_q + 32'h1 : xpos_q - 32'h1; // [RULE10]
    end else begin
      if (xrem_q >= $signed({2'b0, xcpr_q})) begin
        xpos_d = xpos_q + 32'h1; // [RULE8]
        xrem_d = xrem_q - $signed({2'b0, xcpr_q});
      end else if (xrem_q <= -$signed({2'b0, xcpr_q})) begin
        xpos_d = xpos_q - 32'h1;
        xrem_d = xrem_q + $signed({2'b0, xcpr_q});
      end
      if (q_chg) begin
        xrem_d = q_up ? xrem_d + $signed({8'h0, m_step}) : xrem_d - $signed({8'h0, m_step});
      end
    end
    // Sticky errors; a hit in the clearing cycle survives
    dev_err_d = (dev_err_q & ~((wr && !cmd_bank3 && cmd_num == `AESD_AP_DEV_STAT) ?
                 cmd_wdata[1:0] : 2'b00)) | dev_hit; // [RULE19]
    if (cmd_valid && cmd_bank3) begin
      if (cmd_num == `AESD_EV_TMR0 || cmd_num == `AESD_EV_TMR1 ||
          cmd_num == `AESD_EV_TMR2) begin
        if (wr) tmr_per_d[cmd_num[1:0]] = cmd_wdata; // [RULE16]
        rsp_data_d = tmr_per_q[cmd_num[1:0]];
      end else if (cmd_num == `AESD_EV_STOP_L || cmd_num == `AESD_EV_STOP_R) begin
        if (wr) edge_sel_d[3'(cmd_num - `AESD_EV_STOP_L)] = cmd_wdata[1:0]; // [RULE17]
        rsp_data_d = {30'h0, edge_sel_q[3'(cmd_num - `AESD_EV_STOP_L)]};
      end else if (cmd_num >= `AESD_EV_IN0 && cmd_num <= `AESD_EV_IN2) begin
        if (wr) edge_sel_d[3'(cmd_num - `AESD_EV_IN0 + 8'h2)] = cmd_wdata[1:0]; // [RULE17]
        rsp_data_d = {30'h0, edge_sel_q[3'(cmd_num - `AESD_EV_IN0 + 8'h2)]};
      end else begin
        rsp_err_d = 1'b1;
      end
    end else if (cmd_valid) begin
      if (cmd_num == `AESD_AP_RUN_CUR) begin
        if (wr) run_cur_d = cmd_wdata[7:0]; // [RULE13]
        rsp_data_d = {24'h0, run_cur_q};
      end else if (cmd_num == `AESD_AP_STBY_CUR) begin
        if (wr) stby_cur_d = cmd_wdata[7:0]; // [RULE13]
        rsp_data_d = {24'h0, stby_cur_q};
      end else if (cmd_num == `AESD_AP_USTEP) begin
        if (wr && cmd_wdata <= 32'h8) ustep_d = cmd_wdata[3:0]; // [RULE3]
        rsp_err_d = wr && cmd_wdata > 32'h8;
        rsp_data_d = {28'h0, ustep_code_q};
      end else if (cmd_num == `AESD_AP_ENC_POS) begin
        if (wr) enc_acc_d = {cmd_wdata, 10'h0}; // [RULE2]
        rsp_data_d = enc_acc_q[41:F]; // [RULE2]
      end else if (cmd_num == `AESD_AP_ENC_CLR) begin
        if (wr) clr_arm_d = cmd_wdata[0]; // [RULE4]
        rsp_data_d = {31'h0, clr_arm_q};
      end else if (cmd_num == `AESD_AP_ENC_DEV) begin
        if (wr) dev_max_d = cmd_wdata; // [RULE5]
        rsp_data_d = dev_max_q;
      end else if (cmd_num == `AESD_AP_ENC_ABS) begin
        rsp_err_d = wr;
        rsp_data_d = {22'h0, enc_angle}; // [RULE6]
      end else if (cmd_num == `AESD_AP_XENC_POS) begin
        if (wr) begin
          xpos_d = cmd_wdata; // [RULE7]
          xrem_d = 34'h0;
        end
        rsp_data_d = xpos_q; // [RULE7]
      end else if (cmd_num == `AESD_AP_XENC_CPR) begin
        if (wr) begin
          xcpr_d = cmd_wdata; // [RULE8]
          xrem_d = 34'h0;
        end
        rsp_data_d = xcpr_q;
      end else if (cmd_num == `AESD_AP_XENC_DEV) begin
        if (wr) xdev_max_d = cmd_wdata; // [RULE9]
        rsp_data_d = xdev_max_q;
      end else if (cmd_num == `AESD_AP_DEV_STAT) begin
        rsp_data_d = {30'h0, dev_err_q};
      end else if (cmd_num == `AESD_AP_STEPDIR) begin
        if (wr) stepdir_d = cmd_wdata[0]; // [RULE12]
        rsp_data_d = {31'h0, stepdir_mode_q};
      end else begin
        rsp_err_d = 1'b1;
        rsp_data_d = 32'h0;
      end
    end
    if (rd && rsp_err_d) rsp_data_d = 32'h0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_per_q <= '{3{32'h0}};
      edge_sel_q <= '{5{2'h0}};
      ustep_code_q <= `AESD_USTEP_RST; // [RULE18]
      run_cur_q <= `AESD_RUN_CUR_RST;
      stby_cur_q <= `AESD_STBY_CUR_RST;
      enc_acc_q <= 42'h0;
      ang_prev_q <= 10'h0;
      clr_arm_q <= 1'b0;
      dev_max_q <= 32'h0;
      xdev_max_q <= 32'h0;
      xcpr_q <= 32'h0;
      xpos_q <= 32'h0;
      xrem_q <= 34'h0;
      stepdir_mode_q <= 1'b0;
      dev_err_q <= 2'h0;
      stop_req_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_err_q <= 1'b0;
      rsp_data_q <= 32'h0;
    end else begin
      tmr_per_q <= tmr_per_d;
      edge_sel_q <= edge_sel_d;
      ustep_code_q <= ustep_d;
      run_cur_q <= run_cur_d;
      stby_cur_q <= stby_cur_d;
      enc_acc_q <= enc_acc_d;
      ang_prev_q <= enc_angle;
      clr_arm_q <= clr_arm_d;
      dev_max_q <= dev_max_d;
      xdev_max_q <= xdev_max_d;
      xcpr_q <= xcpr_d;
      xpos_q <= xpos_d;
      xrem_q <= xrem_d;
      stepdir_mode_q <= stepdir_d;
      dev_err_q <= dev_err_d;
      stop_req_q <= |dev_err_d; // [RULE5] [RULE9]
      rsp_valid_q <= rsp_valid_d;
      rsp_err_q <= rsp_err_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // ==========================================
  // Motion path, current selection, millisecond tick
  logic        mot_valid_d, step_d, ms_tick;
  logic [31:0] ms_cnt_q, ms_cnt_d, idle_q, idle_d;
  logic [7:0]  cur_d;
  assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
  always_comb begin
    // Step pulses come only from the pins in this mode; commands are dropped
    mot_valid_d = mcmd_valid & ~stepdir_mode_q; // [RULE12]
    step_d = stepdir_mode_q & sync2_q[2] & ~prev_q[2]; // [RULE12]
    ms_cnt_d = ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
    idle_d = idle_q;
    if (motion_active || step_d) idle_d = 32'h0;
    else if (ms_tick && idle_q < `AESD_STBY_MS) idle_d = idle_q + 32'h1;
    cur_d = (idle_d >= `AESD_STBY_MS) ? stby_cur_q : run_cur_q; // [RULE13]
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      mot_valid_q <= 1'b0;
      mot_code_q <= AESD_HALT_MOTION_CMD;
      mot_value_q <= 32'h0;
      step_out_q <= 1'b0;
      dir_out_q <= 1'b0;
      ms_cnt_q <= 32'h0;
      idle_q <= 32'h0;
      coil_current_q <= 8'h0;
    end else begin
      mot_valid_q <= mot_valid_d;
      mot_code_q <= mcmd_code;
      mot_value_q <= mcmd_value;
      step_out_q <= step_d;
      dir_out_q <= sync2_q[3];
      ms_cnt_q <= ms_cnt_d;
      idle_q <= idle_d;
      coil_current_q <= cur_d;
    end
  end

  // ==========================================
  // Event sources: bit order equals event number order
  logic [7:0] ev_new;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_src
      if (gi < 3) begin : g_tmr
        logic [31:0] cnt_q, cnt_d;
        logic        fire;
        always_comb begin
          fire = 1'b0;
          cnt_d = cnt_q;
          if (tmr_per_d[gi] != tmr_per_q[gi] || tmr_per_q[gi] == 32'h0) begin
            cnt_d = 32'h0;
          end else if (ms_tick) begin
            fire = (cnt_q + 32'h1 >= tmr_per_q[gi]); // [RULE16]
            cnt_d = fire ? 32'h0 : cnt_q + 32'h1;
          end
        end
        always_ff @(posedge clk) begin
          if (rst) cnt_q <= 32'h0;
          else cnt_q <= cnt_d;
        end
        assign ev_new[gi] = fire;
      end else begin : g_edge
        logic s, p;
        assign s = sync2_q[gi + 1];
        assign p = prev_q[gi + 1];
        assign ev_new[gi] = // [RULE17]
          ((edge_sel_q[gi - 3] == `AESD_EDGE_RISE || edge_sel_q[gi - 3] == `AESD_EDGE_BOTH)
            && s && !p) ||
          ((edge_sel_q[gi - 3] == `AESD_EDGE_FALL || edge_sel_q[gi - 3] == `AESD_EDGE_BOTH)
            && !s && p);
      end
    end
  endgenerate

  // Server: one event shown at a time until acknowledged
  aesd_evst_e ev_st_q, ev_st_d;
  logic [7:0] pend_q, pend_d, take;
  logic [7:0] evn_d;
  always_comb begin
    take = 8'h0;
    ev_st_d = ev_st_q;
    evn_d = evt_num_q;
    case (ev_st_q)
      AESD_EV_IDLE: begin
        for (int k = 7; k >= 0; k--) begin
          if (pend_q[k]) take = 8'h1 << k; // [RULE15]
        end
        for (int k = 0; k < 8; k++) begin
          if (take[k]) evn_d = EVNUM[k];
        end
        if (pend_q != 8'h0) ev_st_d = AESD_EV_SHOW;
      end
      AESD_EV_SHOW: begin
        if (evt_ack) ev_st_d = AESD_EV_IDLE;
      end
      default: ev_st_d = AESD_EV_IDLE;
    endcase
    pend_d = (pend_q & ~take) | ev_new;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_st_q <= AESD_EV_IDLE;
      pend_q <= 8'h0;
      evt_valid_q <= 1'b0;
      evt_num_q <= 8'h0;
    end else begin
      ev_st_q <= ev_st_d;
      pend_q <= pend_d;
      evt_valid_q <= (ev_st_d == AESD_EV_SHOW);
      evt_num_q <= evn_d;
    end
  end

  // ==========================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_NO_MOTION_IN_SD: assert property (mcmd_valid && stepdir_mode_q |=> !mot_valid_q) // [RULE12]
    else $error("motion command passed in step/direction mode");
  AST_DEV_STOP: assert property (dev_hit[0] |=> dev_err_q[0] && stop_req_q) // [RULE5]
    else $error("built-in deviation did not stop motor");
  AST_DEV_OFF: assert property (dev_max_q == 32'h0 && !dev_err_q[0] |=> !dev_err_q[0]) // [RULE5]
    else $error("deviation flag with check disabled");
  AST_XDEV_STOP: assert property (dev_hit[1] |=> dev_err_q[1] && stop_req_q) // [RULE9]
    else $error("external deviation did not stop motor");
  AST_ABS_READ: assert property (rd && !cmd_bank3 && cmd_num == `AESD_AP_ENC_ABS // [RULE6]
    |=> rsp_valid_q && rsp_data_q == {22'h0, $past(enc_angle)})
    else $error("absolute angle readback wrong");
  AST_CLR_DONE: assert property (clr_arm_q && enc_angle == 10'h0 && ang_prev_q != 10'h0 // [RULE4]
    && !wr |=> !clr_arm_q && enc_acc_q == 42'h0)
    else $error("clear-on-null did not clear and disarm");
  AST_ENC_WRITE: assert property (wr && !cmd_bank3 && cmd_num == `AESD_AP_ENC_POS // [RULE2]
    |=> enc_acc_q[41:F] == $past(cmd_wdata) && rsp_valid_q)
    else $error("encoder write not taken");
  AST_PRIO: assert property (ev_st_q == AESD_EV_IDLE && pend_q[0] // [RULE15]
    |=> evt_valid_q && evt_num_q == `AESD_EV_TMR0)
    else $error("lowest event not served first");
  AST_XENC_ONE: assert property (xcpr_q == 32'h0 && q_chg && q_up && !wr // [RULE10]
    |=> xpos_q == $past(xpos_q) + 32'h1)
    else $error("external count not one to one");
endmodule : aesd_top

// File: hw/aesd_consts.svh
// Parameter numbers, reset values and timing counts of the axis feedback block
`ifndef AESD_CONSTS_SVH
`define AESD_CONSTS_SVH
// ==========================================
// Axis parameter numbers
`define AESD_AP_RUN_CUR   8'h06
`define AESD_AP_STBY_CUR  8'h07
`define AESD_AP_USTEP     8'h8c
`define AESD_AP_ENC_POS   8'hd1
`define AESD_AP_ENC_CLR   8'hd2
`define AESD_AP_ENC_DEV   8'hd4
`define AESD_AP_ENC_ABS   8'hd7
`define AESD_AP_XENC_POS  8'hd8
`define AESD_AP_XENC_CPR  8'hd9
`define AESD_AP_XENC_DEV  8'hda
`define AESD_AP_DEV_STAT  8'hfb
`define AESD_AP_STEPDIR   8'hfe
// ==========================================
// Event parameter numbers, one per source
`define AESD_EV_TMR0      8'h00
`define AESD_EV_TMR1      8'h01
`define AESD_EV_TMR2      8'h02
`define AESD_EV_STOP_L    8'h1b
`define AESD_EV_STOP_R    8'h1c
`define AESD_EV_IN0       8'h27
`define AESD_EV_IN1       8'h28
`define AESD_EV_IN2       8'h29
// ==========================================
// Edge select codes
`define AESD_EDGE_RISE    2'h1
`define AESD_EDGE_FALL    2'h2
`define AESD_EDGE_BOTH    2'h3
// ==========================================
// Reset values
`define AESD_USTEP_RST    4'h8
`define AESD_RUN_CUR_RST  8'h80
`define AESD_STBY_CUR_RST 8'h10
// ==========================================
// Timing
`define AESD_CLK_NS       5
`define AESD_MS_NS        1000000
`define AESD_STBY_MS      32'h000000c8
`define AESD_ENC_FRAC     10
`endif

// File: hw/aesd_pkg.sv
// Types shared by the axis feedback block
package aesd_pkg;
  // ==========================================
  // Motion command codes
  typedef enum logic [1:0] {
    AESD_ROTATE_LEFT_CMD    = 2'h0,
    AESD_TURN_CLOCKWISE_CMD = 2'h1,
    AESD_HALT_MOTION_CMD    = 2'h2,
    AESD_MOVE_TO_POS_CMD    = 2'h3
  } aesd_mcmd_e;
  // ==========================================
  // Event server states
  typedef enum logic [1:0] {
    AESD_EV_IDLE = 2'b01,
    AESD_EV_SHOW = 2'b10
  } aesd_evst_e;
endpackage : aesd_pkg

// File: tb/aesd_host_model.sv
// Host-side model that acknowledges each shown event after a chosen delay
`timescale 1ns/100ps
module aesd_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Event handshake
  input  wire logic       evt_valid,
  input  wire logic [2:0] ack_delay,
  output logic            evt_ack
);
  logic [2:0] wait_q;
  // ==========================================
  // One ack per shown event; a long delay checks that the event is held
  always_ff @(posedge clk) begin
    if (rst || !evt_valid) begin
      wait_q  <= 3'h0;
      evt_ack <= 1'b0;
    end else begin
      wait_q  <= (wait_q == ack_delay) ? wait_q : wait_q + 3'h1;
      evt_ack <= (wait_q == ack_delay) && !evt_ack;
    end
  end
endmodule : aesd_host_model

// File: tb/aesd_tb.sv
// Self-checking bench of the axis feedback block
`timescale 1ns/100ps
`include "aesd_consts.svh"
module testbench import aesd_pkg::*; ;
  typedef struct {logic chk; logic err; logic [31:0] d;} aesd_tb_rsp_s;
  logic clk = 1'b0, rst = 1'b1, cmd_valid, cmd_set, cmd_bank3, mcmd_valid, motion_active;
  logic quad_a, quad_b, step_in, dir_in, stop_left, stop_right, evt_ack, evt_p;
  logic rsp_valid_q, rsp_err_q, mot_valid_q, stop_req_q, step_out_q, dir_out_q;
  logic stepdir_mode_q, evt_valid_q;
  logic [7:0]  cmd_num, coil_current_q, evt_num_q;
  logic [31:0] cmd_wdata, mcmd_value, motor_pos, rsp_data_q, mot_value_q, rv, seed;
  logic [9:0]  enc_angle;
  logic [3:0]  ustep_code_q;
  logic [2:0]  general_in, ack_delay;
  aesd_mcmd_e  mcmd_code, mot_code_q;
  aesd_tb_rsp_s rq[$], r;
  logic [7:0]  eq[$];
  logic [33:0] mq[$];
  int mismatches = 0, n_compared = 0, n_step = 0, cyc = 0;
  always #2.5 clk = ~clk;
  aesd_top #(.FULL_STEPS(200), .MS_CYCLES(10)) i_dut (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_set(cmd_set), .cmd_bank3(cmd_bank3), .cmd_num(cmd_num),
    .cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q), .rsp_err_q(rsp_err_q),
    .rsp_data_q(rsp_data_q), .mcmd_valid(mcmd_valid), .mcmd_code(mcmd_code),
    .mcmd_value(mcmd_value), .mot_valid_q(mot_valid_q), .mot_code_q(mot_code_q),
    .mot_value_q(mot_value_q), .motor_pos(motor_pos), .motion_active(motion_active),
    .enc_angle(enc_angle), .stop_req_q(stop_req_q), .step_out_q(step_out_q),
    .dir_out_q(dir_out_q), .stepdir_mode_q(stepdir_mode_q), .ustep_code_q(ustep_code_q),
    .coil_current_q(coil_current_q), .quad_a(quad_a), .quad_b(quad_b), .step_in(step_in),
    .dir_in(dir_in), .stop_left(stop_left), .stop_right(stop_right),
    .general_in(general_in), .evt_ack(evt_ack), .evt_valid_q(evt_valid_q),
    .evt_num_q(evt_num_q));
  aesd_host_model i_host (.clk(clk), .rst(rst), .evt_valid(evt_valid_q),
    .ack_delay(ack_delay), .evt_ack(evt_ack));
  // ==========================================
  // Compare and closing tasks
  task automatic cmp(input logic [33:0] e, input logic [33:0] a);
    n_compared++;
    if (a !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : cmp
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // ==========================================
  // Drivers; cmd and mc note what they expect back
  task automatic cmd(input logic s, input logic b, input logic [7:0] n, input logic [31:0] w,
                     input logic c, input logic er, input logic [31:0] ed);
    @(negedge clk);
    {cmd_valid, cmd_set, cmd_bank3, cmd_num, cmd_wdata} <= {1'b1, s, b, n, w};
    rq.push_back(aesd_tb_rsp_s'{c, er, ed});
    @(negedge clk);
    cmd_valid <= 1'b0;
  endtask : cmd
  task automatic wr(input logic b, input logic [7:0] n, input logic [31:0] w);
    cmd(1'b1, b, n, w, 1'b0, 1'b0, 32'h0);
  endtask : wr
  task automatic rd(input logic b, input logic [7:0] n, input logic [31:0] ed);
    cmd(1'b0, b, n, 32'h0, 1'b1, 1'b0, ed);
  endtask : rd
  task automatic mc(input aesd_mcmd_e c, input logic [31:0] v, input logic ex);
    @(negedge clk);
    mcmd_valid <= 1'b1;
    mcmd_code  <= c;
    mcmd_value <= v;
    if (ex) mq.push_back({c, v});
    @(negedge clk);
    mcmd_valid <= 1'b0;
  endtask : mc
  task automatic quad(input int n);
    repeat (n) begin
      repeat (4) @(negedge clk);
      {quad_a, quad_b} <= {~quad_b, quad_a};
    end
  endtask : quad
  task automatic pulse(input int n);
    repeat (n) begin
      step_in <= 1'b1;
      repeat (4) @(negedge clk);
      step_in <= 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask : pulse
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // ==========================================
  // Watchers take the oldest note whenever a result shows
  always @(negedge clk) begin
    if (rsp_valid_q === 1'b1) begin
      r = rq.size() ? rq.pop_front() : aesd_tb_rsp_s'{1'b1, 1'b1, 32'hffffffff};
      cmp({1'b0, r.err, r.chk ? r.d : 32'h0},
          {1'b0, rsp_err_q, r.chk ? rsp_data_q : 32'h0});
    end
    if (mot_valid_q === 1'b1)
      cmp(mq.size() ? mq.pop_front() : 34'h0, {mot_code_q, mot_value_q});
    if (evt_valid_q === 1'b1 && evt_p !== 1'b1)
      cmp(eq.size() ? eq.pop_front() : 8'hff, evt_num_q);
    evt_p = evt_valid_q;
    if (step_out_q === 1'b1) n_step++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    seed = 32'h61650da7;
    rv = $random(seed);
    {cmd_valid, cmd_set, cmd_bank3, cmd_num, cmd_wdata, mcmd_valid, mcmd_value} = '0;
    {motor_pos, motion_active, quad_a, quad_b, step_in, dir_in, stop_left, stop_right} = '0;
    general_in = 3'h0;
    mcmd_code = AESD_HALT_MOTION_CMD;
    enc_angle = {1'b0, 9'($random(seed))} | 10'h1;
    ack_delay = 3'($random(seed));
    idle(4);
    rst <= 1'b0;
    rd(1'b0, `AESD_AP_USTEP, 32'h8);
    rd(1'b1, `AESD_EV_TMR0, 32'h0);
    rd(1'b0, `AESD_AP_ENC_ABS, {22'h0, enc_angle});
    cmd(1'b1, 1'b0, `AESD_AP_ENC_ABS, rv, 1'b0, 1'b1, 32'h0);
    // Refused settings answer with the error flag and change nothing
    cmd(1'b1, 1'b0, `AESD_AP_USTEP, 32'h9, 1'b0, 1'b1, 32'h0);
    cmd(1'b0, 1'b0, 8'h01, 32'h0, 1'b1, 1'b1, 32'h0);
    rd(1'b0, `AESD_AP_USTEP, 32'h8);
    wr(1'b0, `AESD_AP_ENC_POS, rv);
    rd(1'b0, `AESD_AP_ENC_POS, rv);
    wr(1'b0, `AESD_AP_XENC_POS, ~rv);
    rd(1'b0, `AESD_AP_XENC_POS, ~rv);
    for (int i = 0; i < 4; i++) mc(aesd_mcmd_e'(i), rv + i, 1'b1);
    // Lines times four gives one count per edge at 200 x 256
    wr(1'b0, `AESD_AP_XENC_CPR, 32'd4 * 32'd12800);
    wr(1'b0, `AESD_AP_XENC_POS, 32'h0);
    quad(8);
    idle(4);
    rd(1'b0, `AESD_AP_XENC_POS, 32'h8);
    // Zero resolution counts every quadrature edge directly
    wr(1'b0, `AESD_AP_XENC_CPR, 32'h0);
    quad(4);
    idle(4);
    rd(1'b0, `AESD_AP_XENC_POS, 32'hc);
    // Positions kept far above the external count so only one check trips
    wr(1'b0, `AESD_AP_ENC_POS, {4'h1, rv[27:0]});
    motor_pos <= {4'h1, rv[27:0]} + 32'h8;
    wr(1'b0, `AESD_AP_ENC_DEV, 32'ha);
    idle(4);
    cmp(1'b0, stop_req_q);
    motor_pos <= {4'h1, rv[27:0]} + 32'hb;
    idle(4);
    cmp(1'b1, stop_req_q);
    wr(1'b0, `AESD_AP_ENC_DEV, 32'h0);
    wr(1'b0, `AESD_AP_XENC_DEV, 32'h2);
    wr(1'b0, `AESD_AP_DEV_STAT, 32'h3);
    idle(4);
    cmp(1'b1, stop_req_q);
    wr(1'b0, `AESD_AP_XENC_DEV, 32'h0);
    wr(1'b0, `AESD_AP_DEV_STAT, 32'h3);
    idle(4);
    cmp(1'b0, stop_req_q);
    wr(1'b0, `AESD_AP_ENC_CLR, 32'h1);
    rd(1'b0, `AESD_AP_ENC_CLR, 32'h1);
    enc_angle <= 10'h0;
    idle(4);
    rd(1'b0, `AESD_AP_ENC_CLR, 32'h0);
    rd(1'b0, `AESD_AP_ENC_POS, 32'h0);
    wr(1'b1, `AESD_EV_STOP_L, `AESD_EDGE_RISE);
    wr(1'b1, `AESD_EV_STOP_R, `AESD_EDGE_FALL);
    wr(1'b1, `AESD_EV_IN0, `AESD_EDGE_BOTH);
    wr(1'b1, `AESD_EV_IN1, 32'h0);
    eq.push_back(8'd27);
    eq.push_back(8'd39);
    // A long acknowledge delay checks that a shown event is held
    ack_delay <= 3'($random(seed)) | 3'h4;
    {stop_left, general_in[1:0]} <= 3'b111;
    idle(20);
    eq.push_back(8'd39);
    {stop_left, general_in[1:0]} <= 3'b000;
    stop_right <= 1'b1;
    idle(20);
    eq.push_back(8'd28);
    stop_right <= 1'b0;
    idle(20);
    eq.push_back(8'd0);
    wr(1'b1, `AESD_EV_TMR0, 32'h3);
    for (int k = 0; k < 100 && eq.size() != 0; k++) @(negedge clk);
    wr(1'b1, `AESD_EV_TMR0, 32'h0);
    cmp(0, eq.size());
    pulse(1);
    cmp(0, n_step);
    wr(1'b0, `AESD_AP_STEPDIR, 32'h1);
    mc(AESD_HALT_MOTION_CMD, rv, 1'b0);
    dir_in <= rv[0];
    pulse(3);
    cmp({32'd3, rv[0], 1'b1}, {n_step, dir_out_q, stepdir_mode_q});
    motion_active <= 1'b1;
    wr(1'b0, `AESD_AP_RUN_CUR, 32'h55);
    wr(1'b0, `AESD_AP_USTEP, 32'h4);
    idle(4);
    cmp({8'h55, 4'h4}, {coil_current_q, ustep_code_q});
    // Standby needs 200 idle milliseconds, 2000 cycles at the bench tick rate
    motion_active <= 1'b0;
    idle(2020);
    cmp(`AESD_STBY_CUR_RST, coil_current_q);
    cmp(0, rq.size() + mq.size());
    stop_test();
  end
endmodule : testbench
